//--- sei_bus_master.sv
// Two-wire bus master model driving the clock and data lines
module sei_bus_master
(
	output logic      scl,      // Bus clock, always driven
	output logic      sda_drv,  // High pulls the data wire low
	input  wire logic sda       // Resolved data wire level
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int Q = 100;  // Quarter of the 400 ns bus clock
	logic s;

	// Idle bus from time zero
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b0;
	end

	// One clock pulse; long low phase covers the slave's drive latency
	task automatic clk(output logic v);
		#(Q+80) scl = 1'b1;
		#(Q+10) v = sda;
		#10 scl = 1'b0;
		#Q;
	endtask

	// Data falls while clock high
	task automatic start();
		sda_drv = 1'b0;
		#Q scl = 1'b1;
		#(2*Q) sda_drv = 1'b1;
		#(2*Q) scl = 1'b0;
		#Q;
	endtask

	// Data rises while clock high
	task automatic stop();
		sda_drv = 1'b1;
		#Q scl = 1'b1;
		#(2*Q) sda_drv = 1'b0;
		#(2*Q);
	endtask

	// Sends n bits MSB first; a whole byte also takes the acknowledge
	task automatic wr_byte(input logic [7:0] b, input int n, output logic ack);
		ack = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			sda_drv = ~b[7-i];
			clk(s);
		end
		if (n == 8)
		begin
			sda_drv = 1'b0;
			clk(s);
			ack = (s === 1'b0);
		end
	endtask

	// Takes a byte, then acknowledges or withholds it
	task automatic rd_byte(input logic ack_out, output logic [7:0] b);
		sda_drv = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			clk(s);
			b[7-i] = s;
		end
		sda_drv = ack_out;
		clk(s);
	endtask

	// Clock pulse shorter than the rejection time
	task automatic glitch();
		scl = 1'b1;
		#40 scl = 1'b0;
	endtask
endmodule

//--- sei_pin_filt.sv
// Two-flop synchroniser with pulse rejection for one bus pin
module sei_pin_filt
	import sei_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
)
(
	input  wire logic clock,     // System clock
	input  wire logic sys_rst,   // Asynchronous reset, active high
	input  wire logic pin_in,    // Raw pin level
	output logic      pin_filt   // Synchronised, filtered level
);

	logic       sync1_r;
	logic       sync2_r;
	logic [1:0] cnt_r;

	// ****************************************
	// Synchroniser
	// ****************************************
	// First flop feeds only the second
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_r <= RST_VAL;
			sync2_r <= RST_VAL;
		end
		else
		begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// ****************************************
	// Pulse filter
	// ****************************************
	// A change must hold for the noise time before it is taken
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_r    <= 2'h0;
			pin_filt <= RST_VAL;
		end
		else if (sync2_r == pin_filt)
			cnt_r <= 2'h0;
		else if (cnt_r == FILT_LAST)
		begin
			cnt_r    <= 2'h0;
			pin_filt <= sync2_r;                // R23
		end
		else
			cnt_r <= cnt_r + 2'h1;
	end

endmodule

//--- sei_pkg.sv
// Shared constants and types for the two-wire serial EEPROM slave
package sei_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;                 // System clock period
	localparam int NOISE_NS      = 100;                // Shortest pulse kept on a pin
	// Stable samples a pin needs before a change is taken, rounded up
	localparam logic [1:0] FILT_CYC = 2'((NOISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] FILT_LAST = FILT_CYC - 2'h1;

	// ****************************************
	// Byte framing and addressing
	// ****************************************
	localparam logic [3:0] TYPE_CODE   = 4'hA;         // Fixed device type code
	localparam logic [3:0] BIT_LAST    = 4'h7;         // Rising edges before the eighth
	localparam logic [3:0] BIT_ACK     = 4'h8;         // Count during the ninth clock
	localparam logic [3:0] BIT_END     = 4'h9;         // Count after the ninth rise
	localparam logic [3:0] BIT_TENTH   = 4'h1;         // Count during the tenth clock
	localparam int         ADDR_W      = 11;           // Memory address width
	localparam int         PROTECT_BIT = 10;           // Set for the upper half
	localparam int         LAT_W       = 4;            // Page latch index width
	localparam logic [10:0] ADDR_ZERO  = 11'h000;

	// ****************************************
	// Protocol states
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,    // Standby
		ST_DEV  = 3'h1,    // Taking the device address byte
		ST_WADR = 3'h3,    // Taking the memory address byte
		ST_WDAT = 3'h2,    // Taking write data
		ST_RDAT = 3'h6,    // Sending read data
		ST_WAIT = 3'h7     // Not addressed, waiting for a start
	} sei_state_t;

endpackage

//--- sei_slave.sv
// Slave protocol engine of a 2K x 8 two-wire serial EEPROM
// What this block does
// (R1) Start and stop framed by SDA while SCL high
// (R2) Receiver pulls SDA low on ninth clock
// (R3) Missing master acknowledge ends read, standby
// (R4) Address byte: type 1010, high bits, direction
// (R5) Direction one reads, zero writes
// (R6) Write bits sampled at SCL rise
// (R7) Read bits shifted out at SCL fall
// (R8) Address: three bits plus next byte
// (R9) Memory address byte only in writes
// (R10) Byte write acknowledged byte by byte
// (R11) Valid stop starts programming, inputs then ignored
// (R12) Protected upper half with WP: no programming
// (R13) Page write: sixteen bytes, counter advances
// (R14) Programming only on stop after acknowledge
// (R15) Silent to polling until programming done
// (R16) Master polls or waits full programming time
// (R17) Bus ignored while power-on reset active
// (R18) Current read sends counter byte, then increments
// (R19) Random read: dummy write then read
// (R20) Master acknowledge continues sequential read
// (R21) Counter wraps past last location to zero
// (R22) Master ends read with no acknowledge, stop
// (R23) Pin pulses under noise time rejected
// (R24) Wrong type code: no acknowledge, await start
// (R25) SDA open drain, driven only low
module sei_slave
	import sei_pkg::*;
(
	input  wire logic               clock,        // System clock, 20 MHz
	input  wire logic               sys_rst,      // Asynchronous reset, active high
	input  wire logic               scl_in,       // Bus clock pin
	input  wire logic               sda_in,       // Bus data pin level
	output logic                    sda_out,      // Data pin drive value
	output logic                    sda_oe,       // Data pin driven low when high
	input  wire logic               wp_in,        // Write protect pin
	input  wire logic               por_active,   // Internal power-on reset
	input  wire logic               prog_busy,    // Programming timer running
	output logic [ADDR_W-1:0]       mem_rd_addr,  // Read address to the array
	input  wire logic [7:0]         mem_rd_data,  // Array data at mem_rd_addr
	output logic                    lat_we,       // Page latch write pulse
	output logic [LAT_W-1:0]        lat_addr,     // Page latch index
	output logic [7:0]              lat_data,     // Page latch data
	output logic                    prog_start,   // Start programming pulse
	output logic [ADDR_W-1:0]       prog_addr     // Address of the written page
);

	// ****************************************
	// Pin conditioning
	// ****************************************
	logic scl_f;
	logic sda_f;
	logic wp_f;

	sei_pin_filt #(.RST_VAL(1'b1)) u_scl (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.pin_in   (scl_in),
		.pin_filt (scl_f)
	);

	sei_pin_filt #(.RST_VAL(1'b1)) u_sda (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.pin_in   (sda_in),
		.pin_filt (sda_f)
	);

	sei_pin_filt #(.RST_VAL(1'b0)) u_wp (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.pin_in   (wp_in),
		.pin_filt (wp_f)
	);

	// ****************************************
	// Bus events
	// ****************************************
	sei_state_t        state_r;
	logic              scl_d_r;
	logic              sda_d_r;
	logic [3:0]        bit_cnt_r;
	logic [7:0]        rx_r;
	logic [7:0]        tx_r;
	logic              ack_r;
	logic              got_data_r;
	logic [2:0]        addr_hi_r;
	logic [ADDR_W-1:0] cnt_r;
	logic [ADDR_W-1:0] wr_base_r;

	logic       rise;
	logic       fall;
	logic       start_c;
	logic       stop_c;
	logic       ignore;
	logic       calm;
	logic       byte_done;
	logic       ack_rise;
	logic       ack_fall;
	logic       type_ok;
	logic [7:0] rx_byte;

	// Counter step with roll-over to zero
	function automatic logic [ADDR_W-1:0] inc_addr(input logic [ADDR_W-1:0] a);
		inc_addr = a + ADDR_W'(1);               // R21
	endfunction

	// Previous filtered levels for edge finding
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_d_r <= scl_f;
			sda_d_r <= sda_f;
		end
	end

	// Edge and condition decode
	assign rise      = scl_f & ~scl_d_r;
	assign fall      = ~scl_f & scl_d_r;
	assign start_c   = scl_f & scl_d_r & sda_d_r & ~sda_f;    // R1
	assign stop_c    = scl_f & scl_d_r & ~sda_d_r & sda_f;    // R1
	assign ignore    = por_active | prog_busy | prog_start;   // R11 R15 R17
	assign calm      = ~ignore & ~start_c & ~stop_c;
	assign rx_byte   = {rx_r[6:0], sda_f};
	assign byte_done = rise & (bit_cnt_r == BIT_LAST) & (state_r != ST_RDAT);
	assign ack_rise  = rise & (bit_cnt_r == BIT_ACK);
	assign ack_fall  = fall & (bit_cnt_r == BIT_END);
	assign type_ok   = (rx_byte[7:4] == TYPE_CODE);           // R4

	// ****************************************
	// Protocol state and bit count
	// ****************************************
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r   <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			ack_r     <= 1'b0;
		end
		else if (ignore)
		begin
			state_r   <= ST_IDLE;                // R11 R15 R17
			bit_cnt_r <= 4'h0;
			ack_r     <= 1'b0;
		end
		else if (start_c)
		begin
			state_r   <= ST_DEV;                 // R1
			bit_cnt_r <= 4'h0;
			ack_r     <= 1'b0;
		end
		else if (stop_c)
		begin
			state_r <= ST_IDLE;                  // R1
			ack_r   <= 1'b0;
		end
		else
		begin
			if (ack_fall)
			begin
				bit_cnt_r <= 4'h0;
				ack_r     <= 1'b0;
			end
			else if (rise)
				bit_cnt_r <= bit_cnt_r + 4'h1;
			if (byte_done)
			begin
				unique case (state_r)
					ST_DEV:
					begin
						if (!type_ok)
						begin
							state_r <= ST_WAIT;          // R24
							ack_r   <= 1'b0;
						end
						else
						begin
							state_r <= rx_byte[0] ? ST_RDAT : ST_WADR;   // R5 R9
							ack_r   <= 1'b1;             // R10 R18
						end
					end
					ST_WADR, ST_WDAT:
					begin
						state_r <= ST_WDAT;
						ack_r   <= 1'b1;                 // R10
					end
					default:
						ack_r <= 1'b0;
				endcase
			end
			// No master acknowledge after a sent byte ends the read
			if (ack_rise && state_r == ST_RDAT && !ack_r && sda_f)
				state_r <= ST_IDLE;                      // R3 R22
		end
	end

	// ****************************************
	// Receive shifter
	// ****************************************
	// Write bits taken on the clock rise
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			rx_r <= 8'h00;
		else if (rise && bit_cnt_r <= BIT_LAST)
			rx_r <= rx_byte;                     // R6
	end

	// ****************************************
	// Data pin drive
	// ****************************************
	// Pin only ever pulled low; released on any frame event
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sda_oe <= 1'b0;
			tx_r   <= 8'h00;
		end
		else if (!calm)
			sda_oe <= 1'b0;                      // R25
		else if (fall)
		begin
			if (bit_cnt_r == BIT_ACK)
				sda_oe <= ack_r;                 // R2
			else if (ack_fall && state_r == ST_RDAT)
			begin
				tx_r   <= mem_rd_data;           // R18 R20
				sda_oe <= ~mem_rd_data[7];       // R7 R25
			end
			else if (state_r == ST_RDAT && bit_cnt_r != BIT_END && bit_cnt_r != 4'h0)
			begin
				tx_r   <= {tx_r[6:0], 1'b0};
				sda_oe <= ~tx_r[6];              // R7
			end
			else
				sda_oe <= 1'b0;
		end
	end

	assign sda_out = 1'b0;                       // R25

	// ****************************************
	// Address counter
	// ****************************************
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			addr_hi_r <= 3'h0;
			cnt_r     <= ADDR_ZERO;
			wr_base_r <= ADDR_ZERO;
		end
		else if (calm)
		begin
			if (byte_done && state_r == ST_DEV)
				addr_hi_r <= rx_byte[3:1];               // R8
			if (byte_done && state_r == ST_WADR)
			begin
				cnt_r     <= {addr_hi_r, rx_byte};       // R8 R19
				wr_base_r <= {addr_hi_r, rx_byte};
			end
			else if (byte_done && state_r == ST_WDAT)
				cnt_r <= inc_addr(cnt_r);                // R13
			else if (ack_rise && state_r == ST_RDAT && !ack_r)
				cnt_r <= inc_addr(cnt_r);                // R18 R20 R21
		end
	end

	assign mem_rd_addr = cnt_r;

	// ****************************************
	// Page latch and programming requests
	// ****************************************
	// Each data byte goes to the latch at the counter's low bits
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lat_we     <= 1'b0;
			lat_addr   <= 4'h0;
			lat_data   <= 8'h00;
			got_data_r <= 1'b0;
		end
		else
		begin
			lat_we <= calm & byte_done & (state_r == ST_WDAT);    // R13
			if (calm && byte_done && state_r == ST_WDAT)
			begin
				lat_addr   <= cnt_r[LAT_W-1:0];
				lat_data   <= rx_byte;
				got_data_r <= 1'b1;
			end
			else if (start_c)
				got_data_r <= 1'b0;
		end
	end

	// Stop right after the final acknowledge, not protected
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prog_start <= 1'b0;
			prog_addr  <= ADDR_ZERO;
		end
		else
		begin
			prog_start <= stop_c & ~ignore & (state_r == ST_WDAT)
				& (bit_cnt_r == BIT_TENTH) & got_data_r           // R11 R14
				& ~(wp_f & wr_base_r[PROTECT_BIT]);             // R12
			if (stop_c)
				prog_addr <= wr_base_r;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_rd_addr;
		calm && byte_done && state_r == ST_DEV && type_ok && rx_byte[0];
	endsequence

	sequence s_rd_ack;
		calm && fall && bit_cnt_r == BIT_ACK ##1 sda_oe;
	endsequence

	a_start_dev: assert property (start_c && !ignore |=> state_r == ST_DEV) // R1
		else $error("start did not open an address byte");
	a_stop_idle: assert property (stop_c && !ignore |=> state_r == ST_IDLE) // R1
		else $error("stop did not return to standby");
	a_read_ack: assert property (s_rd_addr |=> state_r == ST_RDAT && ack_r) // R18
		else $error("read address byte not taken");
	a_ack_drive: assert property (s_rd_addr ##[1:400] s_rd_ack |-> ack_r) // R2
		else $error("acknowledge driven without cause");
	a_nack_standby: assert property (calm && ack_rise && state_r == ST_RDAT
		&& !ack_r && sda_f |=> state_r == ST_IDLE) // R3
		else $error("read went on without acknowledge");
	a_type_reject: assert property (calm && byte_done && state_r == ST_DEV
		&& !type_ok |=> state_r == ST_WAIT && !ack_r) // R24
		else $error("foreign type code accepted");
	a_wp_block: assert property (prog_start |-> !$past(wp_f && wr_base_r[PROTECT_BIT])) // R12
		else $error("protected page programmed");
	a_prog_tenth: assert property (prog_start |-> $past(state_r == ST_WDAT
		&& bit_cnt_r == BIT_TENTH && stop_c)) // R14
		else $error("programming started off the tenth clock");
	a_busy_quiet: assert property (ignore |=> !sda_oe && state_r == ST_IDLE) // R11
		else $error("bus answered while busy");
	a_cnt_wrap: assert property (calm && ack_rise && state_r == ST_RDAT && !ack_r
		&& cnt_r == 11'h7FF |=> cnt_r == ADDR_ZERO) // R21
		else $error("address counter did not wrap");
	a_tx_on_fall: assert property ($rose(sda_oe) |-> $past(fall)) // R7
		else $error("data pin pulled away from a clock fall");

endmodule

//--- testbench.sv
// Self-checking bench for the two-wire EEPROM slave engine
module testbench
	import sei_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Signals and instances
	// ****************************************
	logic              clock, sys_rst, scl, m_drv, sda_out, sda_oe, wp_in, por_active;
	logic              prog_busy, lat_we, prog_start, ack;
	logic [ADDR_W-1:0] mem_rd_addr, prog_addr, pa;
	logic [7:0]        mem_rd_data, lat_data, rb;
	logic [LAT_W-1:0]  lat_addr;
	logic [11:0]       lat_q[$];
	int                mismatches, total_checks, prog_cnt, busy_cnt, p0;
	wire               sda;

	// Pull-up wire, low while either party pulls
	assign sda = ~(sda_oe | m_drv);

	sei_slave i_dut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .por_active(por_active),
		.prog_busy(prog_busy), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
		.lat_we(lat_we), .lat_addr(lat_addr), .lat_data(lat_data),
		.prog_start(prog_start), .prog_addr(prog_addr));
	sei_bus_master i_master (.scl(scl), .sda_drv(m_drv), .sda(sda));

	// Clock generator
	always #25 clock = ~clock;

	// Array contents and programming timer
	always @(negedge clock)
	begin
		mem_rd_data <= exp_data(mem_rd_addr);
		if (prog_start === 1'b1)
		begin
			prog_busy <= 1'b1;
			busy_cnt <= 400;
		end
		else if (busy_cnt > 0)
			busy_cnt <= busy_cnt - 1;
		else
			prog_busy <= 1'b0;
	end

	// Capture of latch writes and programming starts, away from the launch edge
	always @(negedge clock)
	begin
		if (lat_we === 1'b1)
			lat_q.push_back({lat_addr, lat_data});
		if (prog_start === 1'b1)
		begin
			prog_cnt++;
			pa = prog_addr;
		end
		if (sda_out !== 1'b0)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: data drive value not low", $time);
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] exp_data(input logic [10:0] a);
		return a[7:0] ^ {a[10:8], 5'h15};
	endfunction

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr_xfer(input logic [10:0] a, input int n);
		i_master.start();
		i_master.wr_byte({4'hA, a[10:8], 1'b0}, 8, ack);
		chk(ack, "no ack on device byte");
		i_master.wr_byte(a[7:0], 8, ack);
		chk(ack, "no ack on address byte");
		for (int i = 0; i < n; i++)
		begin
			i_master.wr_byte(8'(8'h3C + i), 8, ack);
			chk(ack, "no ack on data byte");
		end
		i_master.stop();
		repeat (20) @(negedge clock);
	endtask

	task automatic poll(input logic exp_ack);
		i_master.start();
		i_master.wr_byte(8'hA0, 8, ack);
		chk(ack === exp_ack, "wrong answer to polling");
		i_master.stop();
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 2000 && prog_busy === 1'b1; i++)
			@(negedge clock);
		chk(prog_busy === 1'b0, "programming never ended");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_byte_write();
		p0 = prog_cnt;
		lat_q.delete();
		wr_xfer(11'h123, 1);
		chk(prog_cnt == p0 + 1 && pa === 11'h123, "byte write not programmed");
		chk(lat_q.size() == 1 && lat_q[0] === 12'h33C, "latch write wrong");
		poll(1'b0);
		wait_idle();
		poll(1'b1);
	endtask

	task automatic t_page();
		p0 = prog_cnt;
		lat_q.delete();
		wr_xfer(11'h07A, 16);
		chk(prog_cnt == p0 + 1 && pa === 11'h07A, "page not programmed");
		chk(lat_q.size() == 16, "page latch count wrong");
		foreach (lat_q[i])
			chk(lat_q[i] === {4'(4'hA + i), 8'(8'h3C + i)}, "page entry wrong");
		wait_idle();
	endtask

	task automatic t_protect();
		@(negedge clock) wp_in = 1'b1;
		p0 = prog_cnt;
		wr_xfer(11'h400, 1);
		chk(prog_cnt == p0, "protected write programmed");
		poll(1'b1);
		wr_xfer(11'h3FF, 1);
		chk(prog_cnt == p0 + 1 && pa === 11'h3FF, "lower half blocked");
		@(negedge clock) wp_in = 1'b0;
		wait_idle();
	endtask

	task automatic t_bad_stop();
		p0 = prog_cnt;
		i_master.start();
		i_master.wr_byte(8'hA0, 8, ack);
		i_master.wr_byte(8'h50, 8, ack);
		i_master.wr_byte(8'h99, 8, ack);
		i_master.wr_byte(8'hFF, 4, ack);
		i_master.stop();
		repeat (20) @(negedge clock);
		chk(prog_cnt == p0, "stop inside a byte programmed");
	endtask

	task automatic t_read();
		p0 = prog_cnt;
		wr_xfer(11'h7FE, 0);
		chk(prog_cnt == p0, "address-only write programmed");
		i_master.start();
		i_master.wr_byte(8'hA1, 8, ack);
		chk(ack, "no ack on read device byte");
		for (int i = 0; i < 3; i++)
		begin
			i_master.rd_byte(i < 2, rb);
			chk(rb === exp_data(11'(11'h7FE + i)), "read data wrong");
		end
		i_master.stop();
		i_master.start();
		i_master.wr_byte(8'hA1, 8, ack);
		i_master.rd_byte(1'b0, rb);
		chk(rb === exp_data(11'h001), "current read data wrong");
		repeat (10) @(negedge clock);
		chk(sda === 1'b1, "data held after no ack");
		i_master.stop();
	endtask

	task automatic t_bad_type();
		i_master.start();
		i_master.wr_byte(8'h90, 8, ack);
		chk(ack === 1'b0, "wrong type code acked");
		i_master.wr_byte(8'hA0, 8, ack);
		chk(ack === 1'b0, "byte without start acked");
		i_master.stop();
		poll(1'b1);
	endtask

	task automatic t_por_glitch();
		@(negedge clock) por_active = 1'b1;
		poll(1'b0);
		@(negedge clock) por_active = 1'b0;
		i_master.start();
		i_master.glitch();
		i_master.wr_byte(8'hA0, 8, ack);
		chk(ack, "short pulse taken as a clock");
		i_master.stop();
	endtask

	// Main sequence
	initial
	begin
		clock = 1'b0;
		sys_rst = 1'b1;
		wp_in = 1'b0;
		por_active = 1'b0;
		prog_busy = 1'b0;
		mem_rd_data = 8'h00;
		busy_cnt = 0;
		prog_cnt = 0;
		mismatches = 0;
		total_checks = 0;
		repeat (6) @(posedge clock);
		@(negedge clock) sys_rst = 1'b0;
		repeat (10) @(negedge clock);
		t_byte_write();
		t_page();
		t_protect();
		t_bad_stop();
		t_read();
		t_bad_type();
		t_por_glitch();
		test_done();
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#2000000;
		mismatches++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		test_done();
	end
endmodule
